// file: dpl_core.sv
// Data-processor input path: tag/level store, display address sequence,
// 51-bit M-bus latch, D-bus source priority and M-bus ownership control.
// Assumes all inputs synchronous to CLOCK; the far side obeys hold rules.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dpl_core (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic GENERAL_CLEAR_N,
  input wire logic MAINTENANCE_CONTROL_MODE,
  input wire logic ABORT,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic [2:0] CBUS_ADDR,
  input wire logic [3:0] CBUS_CMD,
  input wire logic [1:0] DBUS_MODIFY_FIELD,
  input wire logic LATCH_CTRL,
  input wire logic [2:0] BUS_SEL,
  input wire logic MEMORY_HOLD_REQUEST_N,
  input wire logic [2:0] REQUESTOR_SELECT_STATUS,
  input wire logic [50:0] MBUS_IN,
  input wire logic [50:0] ISOLIT_DATA,
  input wire logic [3:0] TAG_IDX_A,
  input wire logic [3:0] TAG_IDX_B,
  input wire logic TAG_TO_MBUS,
  input wire logic ADDRESS_TRANSLATE_SEQUENCE,
  input wire logic [1:0] LEVEL_SEL,
  input wire logic [15:0] OFFSET_IN,
  output logic [50:0] DBUS_OUT,
  output logic [2:0] DBUS_SRC,
  output logic LATCH_OE,
  output logic ISOLIT_OE,
  output logic LITERAL_EN,
  output logic ISOLATE_EN,
  output logic [3:0] DISPLAY_REG_ADDR,
  output logic ALU_ADD,
  output logic [2:0] MBUS_TAG_OUT,
  output logic MBUS_TAG_OE,
  output logic [3:0] COND_TAG,
  output logic [7:0] MODULE_ENABLES,
  output logic [2:0] MEM_CTRL_EN,
  output logic PROGRAM_HOLD,
  output logic PARITY_ERROR
);
  logic [3:0] tag_reg [0:15];
  logic [50:0] latch_reg;
  logic [31:0] control_reg;
  logic perr_reg;
  logic [15:0] offs_reg;
  logic [1:0] lvl_reg;
  dpl_pkg::dpl_seq_t seq_reg;
  dpl_pkg::dpl_seq_t seq_next;
  logic clear;
  logic hold;
  logic open_now;
  logic display_mode;
  logic update_mode;
  logic addressed;
  logic micro_ok;
  logic latch_run;
  logic iso_sel;
  logic lo_drive;
  logic [2:0] grant;
  logic [3:0] cur_idx;
  logic [3:0] tag_widx;

  // Lowest-numbered asserted select-status line has highest priority
  function automatic logic [2:0] pick_first(input logic [2:0] req);
    logic [2:0] g;
    g = 3'h0;
    if (req[0]) begin
      g = 3'h1;
    end else if (req[1]) begin
      g = 3'h2;
    end else if (req[2]) begin
      g = 3'h4;
    end
    return g;
  endfunction

  // Odd parity across the whole latch word
  function automatic logic parity_bad(input logic [50:0] w);
    return ~(^w);
  endfunction

  // Low displays sit at 0..2; current display wherever control points
  function automatic logic [3:0] display_addr(input logic [1:0] lvl, input logic [3:0] cur);
    logic [3:0] a;
    a = {2'h0, lvl};
    if (lvl == dpl_pkg::LVL_CURRENT) begin
      a = cur;
    end
    return a;
  endfunction

  // Shared decode terms
  always_comb begin
    clear = ~GENERAL_CLEAR_N;
    hold = ~MEMORY_HOLD_REQUEST_N;
    open_now = LATCH_CTRL | hold;
    display_mode = MAINTENANCE_CONTROL_MODE & ABORT;
    update_mode = MAINTENANCE_CONTROL_MODE & ~ABORT;
    // Microcode updates run normally or in update mode only
    micro_ok = ~MAINTENANCE_CONTROL_MODE | update_mode;
    // In maintenance mode microcode moves the latch only if selected
    latch_run = micro_ok & (~MAINTENANCE_CONTROL_MODE | control_reg[dpl_pkg::C_LATCH_SEL]);
    addressed = (CBUS_ADDR == dpl_pkg::CBUS_SELF);
    iso_sel = addressed & ((CBUS_CMD == dpl_pkg::CMD_LITERAL) | (CBUS_CMD == dpl_pkg::CMD_ISOLATE));
    lo_drive = (addressed & (CBUS_CMD == dpl_pkg::CMD_LO_READ)) | (seq_reg == dpl_pkg::SEQ_FIRST);
    grant = hold ? pick_first(REQUESTOR_SELECT_STATUS) : 3'h0;
    // Current display may not overlay the fixed low displays
    cur_idx = control_reg[dpl_pkg::C_CUR_LSB +: 4];
    if (cur_idx < 4'h3) begin
      cur_idx = 4'h3;
    end
    tag_widx = REG_ADDR[5:2];
  end

  // Two-clock translate: decode on the first, ALU adds on the second
  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      dpl_pkg::SEQ_IDLE: begin
        if (ADDRESS_TRANSLATE_SEQUENCE & micro_ok) begin
          seq_next = dpl_pkg::SEQ_FIRST;
        end
      end
      dpl_pkg::SEQ_FIRST: begin
        seq_next = dpl_pkg::SEQ_SECOND;
      end
      default: begin
        seq_next = dpl_pkg::SEQ_IDLE;
      end
    endcase
  end

  // Sequence state and captured level/offset pair
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      seq_reg <= dpl_pkg::SEQ_IDLE;
      offs_reg <= 16'h0000;
      lvl_reg <= 2'h0;
    end else begin
      seq_reg <= seq_next;
      if ((seq_reg == dpl_pkg::SEQ_IDLE) & ADDRESS_TRANSLATE_SEQUENCE & micro_ok) begin
        offs_reg <= OFFSET_IN;
        lvl_reg <= LEVEL_SEL;
      end
    end
  end

  // Display register select and ALU add strobe
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      DISPLAY_REG_ADDR <= 4'h0;
      ALU_ADD <= 1'b0;
    end else begin
      if (seq_next == dpl_pkg::SEQ_FIRST) begin
        DISPLAY_REG_ADDR <= display_addr(LEVEL_SEL, cur_idx);
      end
      ALU_ADD <= (seq_next == dpl_pkg::SEQ_SECOND);
    end
  end

  // Latch: samples the M-bus each cycle while open and run by microcode or hold, holds once closed
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      latch_reg <= 51'h0;
    end else if (open_now & (latch_run | hold)) begin
      // Memory transfers land even when microcode is frozen
      latch_reg <= MBUS_IN;
    end
  end

  // Tag store: capture from M-bus [3:4] under modify, bus writes in display
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      for (int i = 0; i < dpl_pkg::TAG_N; i++) begin
        tag_reg[i] <= 4'h0;
      end
    end else if (display_mode) begin
      if (REG_WR & (REG_ADDR >= dpl_pkg::A_TAG_BASE) & (REG_ADDR <= dpl_pkg::A_TAG_END)) begin
        tag_reg[tag_widx] <= REG_WDATA[3:0];
      end
    end else if (DBUS_MODIFY_FIELD == dpl_pkg::MOD_LOAD_TAG) begin
      tag_reg[TAG_IDX_A] <= MBUS_IN[dpl_pkg::TAG_LSB +: dpl_pkg::TAG_W];
    end
  end

  // Dual tag read: port A to M-bus field, port B to condition lines
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      MBUS_TAG_OUT <= 3'h0;
      MBUS_TAG_OE <= 1'b0;
      COND_TAG <= 4'h0;
    end else begin
      MBUS_TAG_OUT <= tag_reg[TAG_IDX_A][dpl_pkg::MTAG_W-1:0];
      MBUS_TAG_OE <= TAG_TO_MBUS & addressed;
      COND_TAG <= tag_reg[TAG_IDX_B];
    end
  end

  // D-bus source priority: tag, level/offset, open latch, isolate, latch
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      DBUS_OUT <= 51'h0;
      DBUS_SRC <= dpl_pkg::SRC_NONE;
      LATCH_OE <= 1'b0;
      ISOLIT_OE <= 1'b0;
    end else begin
      LATCH_OE <= 1'b0;
      ISOLIT_OE <= 1'b0;
      if (DBUS_MODIFY_FIELD == dpl_pkg::MOD_DRIVE_TAG) begin
        DBUS_OUT <= {47'h0, tag_reg[TAG_IDX_A]};
        DBUS_SRC <= dpl_pkg::SRC_TAG;
      end else if (lo_drive) begin
        DBUS_OUT <= {33'h0, lvl_reg, offs_reg};
        DBUS_SRC <= dpl_pkg::SRC_LO;
      end else if (open_now) begin
        // Open latch wins over literal and isolate outputs
        DBUS_OUT <= MBUS_IN;
        DBUS_SRC <= dpl_pkg::SRC_LATCH;
        LATCH_OE <= 1'b1;
      end else if (iso_sel) begin
        DBUS_OUT <= ISOLIT_DATA;
        DBUS_SRC <= dpl_pkg::SRC_ISOLIT;
        ISOLIT_OE <= 1'b1;
      end else begin
        // Closed latch is the default source
        DBUS_OUT <= latch_reg;
        DBUS_SRC <= dpl_pkg::SRC_LATCH;
        LATCH_OE <= 1'b1;
      end
    end
  end

  // Submodule enables only when this unit is addressed
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      LITERAL_EN <= 1'b0;
      ISOLATE_EN <= 1'b0;
    end else begin
      LITERAL_EN <= addressed & (CBUS_CMD == dpl_pkg::CMD_LITERAL) & ~open_now;
      ISOLATE_EN <= addressed & (CBUS_CMD == dpl_pkg::CMD_ISOLATE) & ~open_now;
    end
  end

  // Bus ownership: hold suppresses programmed enables and grants one memory control
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      MODULE_ENABLES <= 8'h00;
      MEM_CTRL_EN <= 3'h0;
      PROGRAM_HOLD <= 1'b0;
    end else begin
      PROGRAM_HOLD <= hold;
      MEM_CTRL_EN <= grant;
      if (hold) begin
        MODULE_ENABLES <= 8'h00;
      end else begin
        // One-hot; code 2 reaches the memory control drivers
        MODULE_ENABLES <= 8'h01 << BUS_SEL;
      end
    end
  end

  // Parity check while the latch couples M-bus to D-bus; set wins over clear
  always_ff @(posedge CLOCK) begin
    if (RST | clear) begin
      perr_reg <= 1'b0;
      PARITY_ERROR <= 1'b0;
    end else begin
      PARITY_ERROR <= open_now & control_reg[dpl_pkg::C_PAR_EN] & parity_bad(MBUS_IN);
      if (open_now & control_reg[dpl_pkg::C_PAR_EN] & parity_bad(MBUS_IN)) begin
        perr_reg <= 1'b1;
      end else if (REG_WR & (REG_ADDR == dpl_pkg::A_STATUS) & REG_WDATA[dpl_pkg::S_PERR]) begin
        perr_reg <= 1'b0;
      end
    end
  end

  // Control register write
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      control_reg <= dpl_pkg::CONTROL_RST;
    end else if (REG_WR & (REG_ADDR == dpl_pkg::A_CONTROL)) begin
      control_reg <= {24'h0, REG_WDATA[7:4], 2'h0, REG_WDATA[1:0]};
    end
  end

  // Register read, data valid the cycle after the strobe only
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      if (REG_ADDR == dpl_pkg::A_STATUS) begin
        REG_RDATA <= {22'h0, seq_reg, 1'b0, grant, 1'b0, perr_reg, hold, open_now};
      end else if (REG_ADDR == dpl_pkg::A_CONTROL) begin
        REG_RDATA <= control_reg;
      end else if (REG_ADDR == dpl_pkg::A_LATCH_LO) begin
        REG_RDATA <= latch_reg[31:0];
      end else if (REG_ADDR == dpl_pkg::A_LATCH_HI) begin
        REG_RDATA <= {13'h0, latch_reg[50:32]};
      end else if ((REG_ADDR >= dpl_pkg::A_TAG_BASE) & (REG_ADDR <= dpl_pkg::A_TAG_END)) begin
        REG_RDATA <= {28'h0, tag_reg[tag_widx]};
      end else begin
        REG_RDATA <= 32'h0000_0000;
      end
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// file: dpl_pkg.sv
// Constants for the data-processor D-bus latch and M-bus control block.
// Assumes one 200 MHz clock and a plain register port on the module.
// Contract
// - Sixteen 4-bit tag or level entries
// - Low displays at 0-2, current elsewhere
// - Address computation spans exactly two clocks
// - Tags driven to and captured from [3:4]
// - Dual-port tags: M-bus field and condition lines
// - 51-bit latch loaded by hold or microword
// - Latch transparent while open
// - Latch closes and holds captured data
// - Latch output enables versus literal and isolate
// - Tags have highest D-bus priority
// - Level/offset output has second priority
// - Isolate/literal third, closed latch default; an open latch ranks above isolate/literal
// - Parity checked when latch links M-bus
// - Enables decoded only when unit addressed
// - 3-bit bus field selects one module
// - Memory seizes bus to write latch
// - Wired-OR hold; scan select-status lines
// - Hold overrides programmed enables, enables requestor
// - Highest-priority requestor granted first
// - Display freezes, update runs, unselected frozen
// - General clear zeroes all shift registers; the control register keeps its value
package dpl_pkg;
  localparam int LATCH_W = 51;
  localparam int TAG_W = 4;
  localparam int TAG_N = 16;
  localparam int OFFS_W = 16;
  localparam int NREQ = 3;
  // Clock and the two-clock translate sequence
  localparam int CLK_PERIOD_NS = 5;
  // Unit address of this data processor on the C-bus
  localparam logic [2:0] CBUS_SELF = 3'h0;
  // Module select codes of the bus field
  localparam logic [2:0] SEL_DATA_PROC = 3'h0;
  localparam logic [2:0] SEL_PROG_CTRL = 3'h1;
  localparam logic [2:0] SEL_MEM_CTRL = 3'h2;
  localparam logic [2:0] SEL_MSG_IO = 3'h3;
  localparam logic [2:0] SEL_IT = 3'h5;
  localparam logic [2:0] SEL_ADP = 3'h7;
  // C-bus command codes for this unit
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_LITERAL = 4'h1;
  localparam logic [3:0] CMD_ISOLATE = 4'h2;
  localparam logic [3:0] CMD_LO_READ = 4'h3;
  // D-bus modify field
  localparam logic [1:0] MOD_NONE = 2'h0;
  localparam logic [1:0] MOD_DRIVE_TAG = 2'h1;
  localparam logic [1:0] MOD_LOAD_TAG = 2'h2;
  // D-bus source codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_TAG = 3'h1;
  localparam logic [2:0] SRC_LO = 3'h2;
  localparam logic [2:0] SRC_ISOLIT = 3'h3;
  localparam logic [2:0] SRC_LATCH = 3'h4;
  // Field positions
  localparam int TAG_LSB = 0;
  localparam int MTAG_LSB = 48;
  localparam int MTAG_W = 3;
  // Level selector encoding: 0..2 low displays, 3 current display
  localparam logic [1:0] LVL_CURRENT = 2'h3;
  // Register map (byte addresses)
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CONTROL = 8'h04;
  localparam logic [7:0] A_LATCH_LO = 8'h08;
  localparam logic [7:0] A_LATCH_HI = 8'h0C;
  localparam logic [7:0] A_TAG_BASE = 8'h40;
  localparam logic [7:0] A_TAG_END = 8'h7C;
  // Control fields and reset value
  localparam int C_PAR_EN = 0;
  localparam int C_LATCH_SEL = 1;
  localparam int C_CUR_LSB = 4;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0031;
  // Status fields
  localparam int S_OPEN = 0;
  localparam int S_HOLD = 1;
  localparam int S_PERR = 2;
  localparam int S_GRANT_LSB = 4;
  localparam int S_SEQ_LSB = 8;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND} dpl_seq_t;
endpackage

// file: dpl_core_asserts.sv
// Checker for the D-bus latch and M-bus control block, bound to dpl_core.
// Assumes one CLOCK domain, synchronous RST and registered outputs.
`timescale 1ns/1ps
`default_nettype none
module dpl_core_asserts (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic GENERAL_CLEAR_N,
  input wire logic MAINTENANCE_CONTROL_MODE,
  input wire logic [2:0] CBUS_ADDR,
  input wire logic [3:0] CBUS_CMD,
  input wire logic [1:0] DBUS_MODIFY_FIELD,
  input wire logic LATCH_CTRL,
  input wire logic [2:0] BUS_SEL,
  input wire logic MEMORY_HOLD_REQUEST_N,
  input wire logic [2:0] REQUESTOR_SELECT_STATUS,
  input wire logic ADDRESS_TRANSLATE_SEQUENCE,
  input wire logic [2:0] DBUS_SRC,
  input wire logic ISOLIT_OE,
  input wire logic LITERAL_EN,
  input wire logic ISOLATE_EN,
  input wire logic ALU_ADD,
  input wire logic [7:0] MODULE_ENABLES,
  input wire logic [2:0] MEM_CTRL_EN,
  input wire logic PROGRAM_HOLD
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST || !GENERAL_CLEAR_N);
  // Maintenance mode may freeze state, so most checks watch normal running
  logic run;
  assign run = !MAINTENANCE_CONTROL_MODE;
  a_hold_takes_bus: assert property (run && !MEMORY_HOLD_REQUEST_N |=>
    PROGRAM_HOLD && MODULE_ENABLES == 8'h00) else $error("hold left program enables on");
  a_grant_top_first: assert property (run && !MEMORY_HOLD_REQUEST_N &&
    REQUESTOR_SELECT_STATUS != 3'h0 |=> MEM_CTRL_EN ==
    ($past(REQUESTOR_SELECT_STATUS) & (~$past(REQUESTOR_SELECT_STATUS) + 3'h1)))
    else $error("grant is not the top requestor");
  a_idle_no_grant: assert property (MEMORY_HOLD_REQUEST_N |=>
    MEM_CTRL_EN == 3'h0 && !PROGRAM_HOLD) else $error("grant without hold");
  a_sel_one_hot: assert property (run && MEMORY_HOLD_REQUEST_N |=>
    MODULE_ENABLES == 8'h01 << $past(BUS_SEL)) else $error("module enable not one-hot");
  a_open_mutes_isolit: assert property (run && (LATCH_CTRL || !MEMORY_HOLD_REQUEST_N) |=>
    !ISOLIT_OE) else $error("isolate output on with latch open");
  a_unaddr_quiet: assert property (CBUS_ADDR != dpl_pkg::CBUS_SELF |=>
    !LITERAL_EN && !ISOLATE_EN) else $error("unit enabled while not addressed");
  a_tag_wins_bus: assert property (run && DBUS_MODIFY_FIELD == dpl_pkg::MOD_DRIVE_TAG |=>
    DBUS_SRC == dpl_pkg::SRC_TAG) else $error("tag lost the D-bus");
  a_lo_read_second: assert property (run && DBUS_MODIFY_FIELD != dpl_pkg::MOD_DRIVE_TAG &&
    CBUS_ADDR == dpl_pkg::CBUS_SELF && CBUS_CMD == dpl_pkg::CMD_LO_READ |=>
    DBUS_SRC == dpl_pkg::SRC_LO) else $error("level/offset read lost the D-bus");
  a_add_two_clocks: assert property ($rose(ALU_ADD) |->
    $past(ADDRESS_TRANSLATE_SEQUENCE, 2) ##1 !ALU_ADD) else $error("add not on second clock");
  a_clear_zeroes: assert property (disable iff (RST) !GENERAL_CLEAR_N |=>
    DBUS_SRC == 3'h0 && MEM_CTRL_EN == 3'h0 && !ALU_ADD) else $error("clear left state");
  // Main scenarios
  c_hold: cover property (!MEMORY_HOLD_REQUEST_N ##1 MEM_CTRL_EN != 3'h0);
  c_add: cover property (ALU_ADD);
  c_isolit: cover property (DBUS_SRC == dpl_pkg::SRC_ISOLIT);
endmodule
bind dpl_core dpl_core_asserts dpl_core_asserts_inst (.CLOCK, .RST, .GENERAL_CLEAR_N,
  .MAINTENANCE_CONTROL_MODE, .CBUS_ADDR, .CBUS_CMD, .DBUS_MODIFY_FIELD, .LATCH_CTRL,
  .BUS_SEL, .MEMORY_HOLD_REQUEST_N, .REQUESTOR_SELECT_STATUS, .ADDRESS_TRANSLATE_SEQUENCE,
  .DBUS_SRC, .ISOLIT_OE, .LITERAL_EN, .ISOLATE_EN, .ALU_ADD, .MODULE_ENABLES, .MEM_CTRL_EN,
  .PROGRAM_HOLD);
`default_nettype wire

// file: dpl_requestor.sv
// Model of up to three memory requestors sharing the wired-OR hold line.
// Assumes MC_ENABLE from the block tells each requestor it was served.
`timescale 1ns/1ps
`default_nettype none
module dpl_requestor (
  input wire logic CLOCK,
  input wire logic [2:0] want,
  input wire logic put,
  input wire logic [50:0] data,
  input wire logic [2:0] grant,
  output logic hold_n,
  output logic [2:0] status,
  output logic [50:0] mbus,
  output logic idle
);
  logic [2:0] pend_reg = 3'h0;
  logic [50:0] last_reg = 51'h0_0000_0000_0000;
  // A requestor keeps asking until its own grant; losers retry next clock
  always_ff @(posedge CLOCK) begin
    if (pend_reg == 3'h0) begin
      pend_reg <= want;
    end else begin
      pend_reg <= pend_reg & ~grant;
    end
  end
  // Released bus shows a changing pattern so stale data cannot pass
  always_ff @(posedge CLOCK) begin
    last_reg <= mbus;
  end
  assign hold_n = ~|pend_reg;
  assign status = pend_reg;
  assign mbus = (|pend_reg || put) ? data : ~last_reg;
  assign idle = pend_reg == 3'h0;
endmodule
`default_nettype wire

// file: dp_dbus_latch_and_mbus_control_tb.sv
// Self-checking bench for the D-bus latch and M-bus control block.
// Assumes dpl_pkg, dpl_core, its checker and the requestor model compile first.
`timescale 1ns/1ps
`default_nettype none
module dp_dbus_latch_and_mbus_control_tb;
  // Signals keep the port names so instances connect by name
  logic CLOCK = 1'b0, RST = 1'b1, GENERAL_CLEAR_N = 1'b1, put = 1'b0;
  logic MAINTENANCE_CONTROL_MODE = 1'b0, ABORT = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic LATCH_CTRL = 1'b0, TAG_TO_MBUS = 1'b0, ADDRESS_TRANSLATE_SEQUENCE = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0000_0000;
  logic [2:0] CBUS_ADDR = 3'h0, BUS_SEL = 3'h0, want = 3'h0, first_g, seen;
  logic [3:0] CBUS_CMD = 4'h0, TAG_IDX_A = 4'h0, TAG_IDX_B = 4'h0;
  logic [1:0] DBUS_MODIFY_FIELD = 2'h0, LEVEL_SEL = 2'h0;
  logic [15:0] OFFSET_IN = 16'h0000;
  logic [50:0] ISOLIT_DATA = 51'h1_2345_6789_ABCD, dat = 51'h0_0000_0000_0000;
  logic [50:0] MBUS_IN, DBUS_OUT;
  logic [31:0] REG_RDATA;
  logic [2:0] REQUESTOR_SELECT_STATUS, DBUS_SRC, MBUS_TAG_OUT, MEM_CTRL_EN;
  logic [3:0] DISPLAY_REG_ADDR, COND_TAG;
  logic [7:0] MODULE_ENABLES;
  logic MEMORY_HOLD_REQUEST_N, LATCH_OE, ISOLIT_OE, LITERAL_EN, ISOLATE_EN, ALU_ADD;
  logic MBUS_TAG_OE, PROGRAM_HOLD, PARITY_ERROR, idle;
  int n_errors = 0, checked = 0, cycles = 0;
  // Row: bus select, modify field, command, latch bit, then enables and source
  logic [20:0] rows [8] = '{{3'h0, 2'h1, 4'h3, 1'b1, 8'h01, 3'h1},
    {3'h1, 2'h0, 4'h3, 1'b1, 8'h02, 3'h2}, {3'h2, 2'h0, 4'h1, 1'b1, 8'h04, 3'h4},
    {3'h3, 2'h0, 4'h1, 1'b0, 8'h08, 3'h3}, {3'h4, 2'h0, 4'h2, 1'b0, 8'h10, 3'h3},
    {3'h5, 2'h0, 4'h0, 1'b0, 8'h20, 3'h4}, {3'h6, 2'h0, 4'h0, 1'b0, 8'h40, 3'h4},
    {3'h7, 2'h1, 4'h1, 1'b0, 8'h80, 3'h1}};
  dpl_core dpl_core_inst (.CLOCK, .RST, .GENERAL_CLEAR_N, .MAINTENANCE_CONTROL_MODE, .ABORT,
    .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CBUS_ADDR, .CBUS_CMD,
    .DBUS_MODIFY_FIELD, .LATCH_CTRL, .BUS_SEL, .MEMORY_HOLD_REQUEST_N,
    .REQUESTOR_SELECT_STATUS, .MBUS_IN, .ISOLIT_DATA, .TAG_IDX_A, .TAG_IDX_B, .TAG_TO_MBUS,
    .ADDRESS_TRANSLATE_SEQUENCE, .LEVEL_SEL, .OFFSET_IN, .DBUS_OUT, .DBUS_SRC, .LATCH_OE,
    .ISOLIT_OE, .LITERAL_EN, .ISOLATE_EN, .DISPLAY_REG_ADDR, .ALU_ADD, .MBUS_TAG_OUT,
    .MBUS_TAG_OE, .COND_TAG, .MODULE_ENABLES, .MEM_CTRL_EN, .PROGRAM_HOLD, .PARITY_ERROR);
  dpl_requestor dpl_requestor_inst (.CLOCK, .want, .put, .data(dat), .grant(MEM_CTRL_EN),
    .hold_n(MEMORY_HOLD_REQUEST_N), .status(REQUESTOR_SELECT_STATUS), .mbus(MBUS_IN), .idle);
  always #2.5 CLOCK = ~CLOCK;
  // Cut a hang short well past the hundred or so cycles the run needs
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, e, "read");
  endtask
  // One microword cycle with the latch bit set over fresh M-bus data
  task automatic load(input logic [50:0] d);
    @(posedge CLOCK);
    LATCH_CTRL <= 1'b1;
    put <= 1'b1;
    dat <= d;
    @(posedge CLOCK);
    LATCH_CTRL <= 1'b0;
    put <= 1'b0;
  endtask
  task automatic conclude;
    $display("Errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    #1 chk({DBUS_OUT, DBUS_SRC, MEM_CTRL_EN}, 64'h0, "reset outputs");
    rd(dpl_pkg::A_CONTROL, dpl_pkg::CONTROL_RST);
    rd(dpl_pkg::A_STATUS, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    foreach (rows[i]) begin
      @(posedge CLOCK);
      {BUS_SEL, DBUS_MODIFY_FIELD, CBUS_CMD, LATCH_CTRL} <= rows[i][20:11];
      @(posedge CLOCK);
      #1 chk(MODULE_ENABLES, rows[i][10:3], "enables");
      chk(DBUS_SRC, rows[i][2:0], "source");
      chk({LITERAL_EN, ISOLATE_EN, ISOLIT_OE},
        {rows[i][15:12] == 4'h1 && !rows[i][11], rows[i][15:12] == 4'h2 && !rows[i][11],
        rows[i][2:0] == 3'h3}, "unit enables");
    end
    // Odd parity word passes through open, then is held once closed
    @(posedge CLOCK);
    {BUS_SEL, DBUS_MODIFY_FIELD, CBUS_CMD} <= 9'h000;
    // Idle partner bus toggles, so the sweep above may have flagged parity
    wr(dpl_pkg::A_STATUS, 32'h0000_0004);
    load(51'h7_0F0F_0F0F_0F0F);
    #1 chk({LATCH_OE, PARITY_ERROR, DBUS_OUT},
      {2'h2, 51'h7_0F0F_0F0F_0F0F}, "open");
    repeat (3) @(posedge CLOCK);
    #1 chk({DBUS_SRC, DBUS_OUT}, {3'h4, 51'h7_0F0F_0F0F_0F0F}, "held");
    rd(dpl_pkg::A_STATUS, 32'h0000_0000);
    load(51'h0_0000_0000_0003);
    #1 chk(PARITY_ERROR, 1'b1, "parity flag");
    rd(dpl_pkg::A_STATUS, 32'h0000_0004);
    wr(dpl_pkg::A_STATUS, 32'h0000_0004);
    rd(dpl_pkg::A_STATUS, 32'h0000_0000);
    // Display mode freezes the latch but lets tags be set
    MAINTENANCE_CONTROL_MODE <= 1'b1;
    ABORT <= 1'b1;
    load(51'h7_FFFF_0000_1111);
    wr(8'h54, 32'h0000_000A);
    #1 chk(DBUS_OUT, 51'h0_0000_0000_0003, "frozen");
    ABORT <= 1'b0;
    wr(8'h58, 32'h0000_000B);
    rd(8'h58, 32'h0000_0000);
    rd(8'h54, 32'h0000_000A);
    // Update mode without the latch selected leaves the latch untouched
    load(51'h0_0000_0000_0007);
    @(posedge CLOCK);
    #1 chk(DBUS_OUT, 51'h0_0000_0000_0003, "unselected frozen");
    MAINTENANCE_CONTROL_MODE <= 1'b0;
    // Both tag ports and the tag drive at once
    TAG_IDX_A <= 4'h5;
    TAG_IDX_B <= 4'h5;
    TAG_TO_MBUS <= 1'b1;
    DBUS_MODIFY_FIELD <= 2'h1;
    repeat (2) @(posedge CLOCK);
    #1 chk({COND_TAG, MBUS_TAG_OE, MBUS_TAG_OUT}, {4'hA, 1'b1, 3'h2}, "tag ports");
    chk({DBUS_SRC, DBUS_OUT[3:0]}, {3'h1, 4'hA}, "tag drive");
    @(posedge CLOCK);
    TAG_IDX_A <= 4'h7;
    TAG_IDX_B <= 4'h7;
    DBUS_MODIFY_FIELD <= 2'h2;
    put <= 1'b1;
    dat <= 51'h0_0000_0000_000C;
    @(posedge CLOCK);
    DBUS_MODIFY_FIELD <= 2'h0;
    put <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1 chk(COND_TAG, 4'hC, "tag load");
    wr(dpl_pkg::A_CONTROL, 32'h0000_0091);
    for (int l = 0; l < 4; l++) begin
      @(posedge CLOCK);
      ADDRESS_TRANSLATE_SEQUENCE <= 1'b1;
      LEVEL_SEL <= l[1:0];
      OFFSET_IN <= {14'h048C, l[1:0]};
      @(posedge CLOCK);
      ADDRESS_TRANSLATE_SEQUENCE <= 1'b0;
      #1 chk(DISPLAY_REG_ADDR, (l < 3) ? l : 9, "display");
      @(posedge CLOCK);
      #1 chk({ALU_ADD, DBUS_SRC}, {1'b1, 3'h2}, "add cycle");
      chk(DBUS_OUT[15:0], {14'h048C, l[1:0]}, "offset");
    end
    // Two requestors at once; the higher one must be served first
    @(posedge CLOCK);
    want <= 3'h6;
    dat <= 51'h0_0000_0000_0007;
    @(posedge CLOCK);
    want <= 3'h0;
    first_g = 3'h0;
    seen = 3'h0;
    for (int k = 0; k < 20 && !(idle && k > 2); k++) begin
      @(posedge CLOCK);
      #1 if (first_g == 3'h0) first_g = MEM_CTRL_EN;
      seen = seen | MEM_CTRL_EN;
      if (k == 0) chk({PROGRAM_HOLD, MODULE_ENABLES}, 9'h100, "hold owns bus");
    end
    repeat (2) @(posedge CLOCK);
    #1 chk({first_g, seen}, {3'h2, 3'h6}, "grants");
    chk(DBUS_OUT, 51'h0_0000_0000_0007, "hold data");
    @(posedge CLOCK);
    GENERAL_CLEAR_N <= 1'b0;
    @(posedge CLOCK);
    GENERAL_CLEAR_N <= 1'b1;
    #1 chk({COND_TAG, DBUS_OUT, DBUS_SRC}, 64'h0, "clear");
    @(posedge CLOCK);
    #1 chk({COND_TAG, DBUS_OUT, DBUS_SRC}, {4'h0, 51'h0_0000_0000_0000, 3'h4}, "cleared");
    rd(dpl_pkg::A_CONTROL, 32'h0000_0091);
    CBUS_ADDR <= 3'h1;
    CBUS_CMD <= 4'h1;
    repeat (2) @(posedge CLOCK);
    #1 chk({LITERAL_EN, DBUS_SRC}, {1'b0, 3'h4}, "unaddressed");
    conclude();
  end
endmodule
`default_nettype wire
